// ### logic/fscr_pkg.sv
// Package for the flash status and configuration register bank
package fscr_pkg;

	// Primary status bit positions
	localparam int ST_BUSY      = 0;
	localparam int ST_ARM       = 1;
	localparam int ST_BP_LO     = 2;
	localparam int ST_BP_HI     = 4;
	localparam int ST_ERASE_ERR = 5;
	localparam int ST_PROG_ERR  = 6;
	localparam int ST_LOCK      = 7;

	// Configuration bit positions
	localparam int CF_FREEZE    = 0;
	localparam int CF_QUAD      = 1;
	localparam int CF_PROTECT_VOLATILITY_SEL_SEL  = 3;
	localparam int CF_ORIGIN    = 5;
	localparam int CF_LAT_LO    = 6;
	localparam int CF_LAT_HI    = 7;

	// Suspend status bit positions
	localparam int SS_PROG_SUSP  = 0;
	localparam int SS_ERASE_SUSP = 1;

	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [2:0] BP_RST     = 3'h0;

	// Command events that the decoder hands to the bank
	typedef struct packed {
		logic       arm;        // Write enable command
		logic       disarm;     // Write disable command
		logic       reg_write;  // Register write command, data below
		logic [7:0] wr_status;  // New primary status byte
		logic [7:0] wr_config;  // New configuration byte
		logic       wr_has_cfg; // Second data byte present
	} fscr_cmd_t;

	// Array engine state reported into the flags
	typedef struct packed {
		logic busy;
		logic prog_fail;
		logic erase_fail;
		logic prog_susp;
		logic erase_susp;
		logic clr_err;
	} fscr_eng_t;

	// Register write sequencer states
	typedef enum logic [1:0] {
		WS_IDLE = 2'b00,
		WS_BUSY = 2'b01
	} fscr_wstate_t;

	// Cycles a register write keeps the bank busy
	localparam logic [3:0] WR_BUSY_CYC = 4'h4;

endpackage : fscr_pkg

// ### logic/fscr_regs.sv
// Status and configuration register bank of a serial NOR flash
// What this block does
// [RULE_01] Lock bit plus low protect pin blocks writes
// [RULE_02] Read-only program and erase failure flags
// [RULE_03] Write latch gates register, program, erase commands
// [RULE_04] Only arm/disarm commands change write latch
// [RULE_05] Busy flag shows any operation in progress
// [RULE_06] Two-bit latency field selects dummy cycles
// [RULE_07] One-time bit picks protection origin
// [RULE_08] One-time bit picks protection bit volatility
// [RULE_09] Quad bit enables quad I/O
// [RULE_10] Freeze bit locks protection and origin
// [RULE_11] Erase suspend flag in second status
// [RULE_12] Program suspend flag in second status
// [RULE_13] Upper second status bits read zero
// [RULE_14] Host polls busy and arms before writes
`timescale 1ns/1ns
module fscr_regs (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              wp_pin_n,     // Write-protect pin, active low
	input  wire fscr_pkg::fscr_cmd_t cmd,        // One-cycle command events
	input  wire fscr_pkg::fscr_eng_t eng,        // Array engine state
	output logic [7:0]             status_q,     // Primary status
	output logic [7:0]             config_q,     // Device configuration
	output logic [7:0]             suspend_q,    // Suspend status
	output logic                   array_ok,     // Program/erase may start
	output logic [1:0]             latency_sel,  // Read dummy cycle code
	output logic                   quad_en,      // Quad I/O mode
	output logic                   prot_frozen   // Protection locked
);

	// Synchroniser for the protect pin
	logic wp_s1_r, wp_s2_r;
	// Register state
	logic       lock_r, lock_nxt;
	logic [2:0] bp_r, bp_nxt;
	logic       arm_r, arm_nxt;
	logic       perr_r, perr_nxt;
	logic       eerr_r, eerr_nxt;
	logic [1:0] lat_r, lat_nxt;
	logic       origin_r, origin_nxt;
	logic       protect_volatility_sel_r, protect_volatility_sel_nxt;
	logic       quad_r, quad_nxt;
	logic       frz_r, frz_nxt;
	logic       origin_done_r, origin_done_nxt;  // One-time bit programmed
	logic       protect_volatility_sel_done_r, protect_volatility_sel_done_nxt;
	fscr_pkg::fscr_wstate_t ws_r, ws_nxt;        // Register write sequencer
	logic [3:0] wcnt_r, wcnt_nxt;
	logic       wr_ok;                           // Register write accepted

	// Two flops before the pin is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_s1_r <= 1'b1;
			wp_s2_r <= 1'b1;
		end else begin
			wp_s1_r <= wp_pin_n;
			wp_s2_r <= wp_s1_r;
		end
	end

	// Write accepted only when armed, idle and not hardware locked
	assign wr_ok = cmd.reg_write && arm_r && !status_q[fscr_pkg::ST_BUSY]
		&& !(lock_r && !wp_s2_r);  // see [RULE_03] see [RULE_01] see [RULE_14]

	// Next-state logic for all register fields
	always_comb begin
		lock_nxt        = lock_r;
		bp_nxt          = bp_r;
		arm_nxt         = arm_r;
		perr_nxt        = perr_r;
		eerr_nxt        = eerr_r;
		lat_nxt         = lat_r;
		origin_nxt      = origin_r;
		protect_volatility_sel_nxt        = protect_volatility_sel_r;
		quad_nxt        = quad_r;
		frz_nxt         = frz_r;
		origin_done_nxt = origin_done_r;
		protect_volatility_sel_done_nxt   = protect_volatility_sel_done_r;
		ws_nxt          = ws_r;
		wcnt_nxt        = wcnt_r;
		// Latch follows arm and disarm only
		if (cmd.arm) begin
			arm_nxt = 1'b1;  // see [RULE_04]
		end else if (cmd.disarm) begin
			arm_nxt = 1'b0;  // see [RULE_04]
		end
		// Error flags: a new failure wins over a clear
		if (eng.clr_err) begin
			perr_nxt = 1'b0;
			eerr_nxt = 1'b0;
		end
		if (eng.prog_fail) begin
			perr_nxt = 1'b1;  // see [RULE_02]
		end
		if (eng.erase_fail) begin
			eerr_nxt = 1'b1;  // see [RULE_02]
		end
		// Register write updates
		if (wr_ok) begin
			lock_nxt = cmd.wr_status[fscr_pkg::ST_LOCK];
			if (!frz_r) begin
				bp_nxt = cmd.wr_status[fscr_pkg::ST_BP_HI:fscr_pkg::ST_BP_LO];  // see [RULE_10]
			end
			if (cmd.wr_has_cfg) begin
				lat_nxt  = cmd.wr_config[fscr_pkg::CF_LAT_HI:fscr_pkg::CF_LAT_LO];  // see [RULE_06]
				quad_nxt = cmd.wr_config[fscr_pkg::CF_QUAD];  // see [RULE_09]
				frz_nxt  = frz_r | cmd.wr_config[fscr_pkg::CF_FREEZE];  // see [RULE_10]
				// One-time bits can only be set once, origin also frozen
				if (!origin_done_r && !frz_r && cmd.wr_config[fscr_pkg::CF_ORIGIN]) begin
					origin_nxt      = 1'b1;  // see [RULE_07]
					origin_done_nxt = 1'b1;
				end
				if (!protect_volatility_sel_done_r && cmd.wr_config[fscr_pkg::CF_PROTECT_VOLATILITY_SEL_SEL]) begin
					protect_volatility_sel_nxt      = 1'b1;  // see [RULE_08]
					protect_volatility_sel_done_nxt = 1'b1;
				end
			end
		end
		// Busy window for the register write
		case (ws_r)
			fscr_pkg::WS_IDLE: begin
				// The write latch is left alone here, see [RULE_04]
				if (wr_ok) begin
					ws_nxt   = fscr_pkg::WS_BUSY;
					wcnt_nxt = fscr_pkg::WR_BUSY_CYC;
				end
			end
			fscr_pkg::WS_BUSY: begin
				wcnt_nxt = wcnt_r - 4'h1;
				if (wcnt_r == 4'h1) begin
					ws_nxt = fscr_pkg::WS_IDLE;
				end
			end
			default: begin
				ws_nxt = fscr_pkg::WS_IDLE;
			end
		endcase
	end

	// Register all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r        <= fscr_pkg::STATUS_RST[fscr_pkg::ST_LOCK];
			bp_r          <= fscr_pkg::BP_RST;
			arm_r         <= fscr_pkg::STATUS_RST[fscr_pkg::ST_ARM];  // see [RULE_03]
			perr_r        <= fscr_pkg::STATUS_RST[fscr_pkg::ST_PROG_ERR];
			eerr_r        <= fscr_pkg::STATUS_RST[fscr_pkg::ST_ERASE_ERR];
			lat_r         <= fscr_pkg::CONFIG_RST[fscr_pkg::CF_LAT_HI:fscr_pkg::CF_LAT_LO];
			origin_r      <= fscr_pkg::CONFIG_RST[fscr_pkg::CF_ORIGIN];
			protect_volatility_sel_r        <= fscr_pkg::CONFIG_RST[fscr_pkg::CF_PROTECT_VOLATILITY_SEL_SEL];
			quad_r        <= fscr_pkg::CONFIG_RST[fscr_pkg::CF_QUAD];
			frz_r         <= fscr_pkg::CONFIG_RST[fscr_pkg::CF_FREEZE];
			origin_done_r <= 1'b0;
			protect_volatility_sel_done_r   <= 1'b0;
			ws_r          <= fscr_pkg::WS_IDLE;
			wcnt_r        <= 4'h0;
		end else begin
			lock_r        <= lock_nxt;
			bp_r          <= bp_nxt;
			arm_r         <= arm_nxt;
			perr_r        <= perr_nxt;
			eerr_r        <= eerr_nxt;
			lat_r         <= lat_nxt;
			origin_r      <= origin_nxt;
			protect_volatility_sel_r        <= protect_volatility_sel_nxt;
			quad_r        <= quad_nxt;
			frz_r         <= frz_nxt;
			origin_done_r <= origin_done_nxt;
			protect_volatility_sel_done_r   <= protect_volatility_sel_done_nxt;
			ws_r          <= ws_nxt;
			wcnt_r        <= wcnt_nxt;
		end
	end

	// Read views
	always_comb begin
		status_q = {lock_r, perr_r, eerr_r, bp_r, arm_r,
			eng.busy | (ws_r == fscr_pkg::WS_BUSY)};  // see [RULE_05]
		config_q = {lat_r, origin_r, 1'b0, protect_volatility_sel_r, 1'b0, quad_r, frz_r};
		suspend_q = {6'h00, eng.erase_susp, eng.prog_susp};  // see [RULE_11] see [RULE_12] see [RULE_13]
	end

	// Side outputs
	assign array_ok    = arm_r && !status_q[fscr_pkg::ST_BUSY];  // see [RULE_03]
	assign latency_sel = lat_r;                                  // see [RULE_06]
	assign quad_en     = quad_r;                                 // see [RULE_09]
	assign prot_frozen = frz_r;                                  // see [RULE_10]

	// Assertions
	lock_blocks_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_01]
		(lock_r && !wp_s2_r && cmd.reg_write) |=> $stable(lock_r) && $stable(bp_r)
		&& $stable(config_q))
		else $error("Locked write changed status");
	perr_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_02]
		eng.prog_fail |=> perr_r)
		else $error("Program failure not flagged");
	unarmed_ign_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_03]
		(!arm_r && cmd.reg_write && ws_r == fscr_pkg::WS_IDLE) |=> (ws_r == fscr_pkg::WS_IDLE))
		else $error("Unarmed write accepted");
	arm_only_cmd_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_04]
		(!cmd.arm && !cmd.disarm) |=> $stable(arm_r))
		else $error("Latch moved without command");
	busy_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_05]
		wr_ok |=> status_q[fscr_pkg::ST_BUSY] [*4])
		else $error("Busy not held after write");
	freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_10]
		frz_r |=> frz_r && $stable(bp_r))
		else $error("Frozen protection changed");
	origin_once_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_07]
		origin_r |=> origin_r)
		else $error("Origin bit cleared");
	susp_map_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_13]
		suspend_q[7:2] == 6'h00 && suspend_q[1] == eng.erase_susp
		&& suspend_q[0] == eng.prog_susp)
		else $error("Suspend status wrong");
	wr_cover_c: cover property (@(posedge clk) disable iff (!rst_n) wr_ok);
	lock_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
		lock_r && !wp_s2_r && cmd.reg_write && arm_r);
	frz_cover_c: cover property (@(posedge clk) disable iff (!rst_n) frz_r);
	// Failure and clear in one cycle, the failure must win
	errclr_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
		eng.clr_err && eng.prog_fail);

endmodule : fscr_regs

// ### sim/fscr_host.sv
// Host controller model that issues register commands to the bank
`timescale 1ns/1ns
module fscr_host (
	input  wire logic          clk,
	input  wire logic [7:0]    status_q, // Primary status read back
	output fscr_pkg::fscr_cmd_t cmd      // One-cycle command pulses
);
	// Quiet bus at time zero
	initial cmd = '0;

	// Pulse a command for one cycle, launched on the falling edge
	task automatic pulse(input fscr_pkg::fscr_cmd_t c);
		@(negedge clk);
		cmd = c;
		@(negedge clk);
		cmd = '0;
	endtask : pulse

	// Write enable (a=1) or write disable (a=0)
	task automatic arm(input logic a);
		fscr_pkg::fscr_cmd_t c;
		c = '0;
		c.arm = a;
		c.disarm = !a;
		pulse(c);
	endtask : arm

	// Register write with both bytes; returns the busy cycles seen after it
	task automatic reg_wr(input logic [7:0] st, input logic [7:0] cf, output int nb);
		fscr_pkg::fscr_cmd_t c;
		c = '0;
		nb = 0;
		// Poll busy until idle, bounded so a stuck flag cannot hang us
		for (int i = 0; i < 20 && status_q[0] !== 1'b0; i++) @(negedge clk);
		c.reg_write = 1'b1;
		c.wr_status = st;
		c.wr_config = cf;
		c.wr_has_cfg = 1'b1;
		pulse(c);
		// Count busy over a window longer than any register write
		for (int i = 0; i < 10; i++) begin
			if (status_q[0] === 1'b1) nb++;
			@(negedge clk);
		end
	endtask : reg_wr
endmodule : fscr_host

// ### sim/fscr_regs_tb.sv
// Self-checking bench for the flash status and configuration bank
`timescale 1ns/1ns
module fscr_regs_tb;
	logic                clk;         // 20 MHz clock
	logic                rst_n;       // Reset, active low
	logic                wp_pin_n;    // Write-protect pin
	fscr_pkg::fscr_eng_t eng;         // Array engine state
	fscr_pkg::fscr_cmd_t cmd;         // Commands from the host
	logic [7:0]          status_q;    // Primary status
	logic [7:0]          config_q;    // Configuration
	logic [7:0]          suspend_q;   // Suspend status
	logic                array_ok;    // Program or erase allowed
	logic [1:0]          latency_sel; // Dummy cycle code
	logic                quad_en;     // Quad mode
	logic                prot_frozen; // Protection frozen
	int                  failures;    // Mismatches
	int                  n_tests;     // Comparisons
	int                  cycles;      // Timeout counter
	int                  nb;          // Busy cycles of last write

	fscr_regs u_fscr_regs (.clk(clk), .rst_n(rst_n), .wp_pin_n(wp_pin_n), .cmd(cmd),
		.eng(eng), .status_q(status_q), .config_q(config_q), .suspend_q(suspend_q),
		.array_ok(array_ok), .latency_sel(latency_sel), .quad_en(quad_en),
		.prot_frozen(prot_frozen));
	fscr_host u_fscr_host (.clk(clk), .status_q(status_q), .cmd(cmd));

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compare one byte and log a mismatch
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Counts, verdict, end of run
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end

	// Side outputs packed into one byte for comparison
	function automatic logic [7:0] side();
		return {3'h0, array_ok, prot_frozen, quad_en, latency_sel};
	endfunction : side

	// Settle the synchronised protect pin
	task automatic set_wp(input logic v);
		wp_pin_n = v;
		repeat (3) @(negedge clk);
	endtask : set_wp

	// Reset values and reserved bits
	task automatic t_reset();
		chk(status_q, 8'h00);
		chk(config_q, 8'h00);
		chk(suspend_q, 8'h00);
		chk(side(), 8'h00);
	endtask : t_reset

	// Unarmed write ignored, armed write accepted, latch kept
	task automatic t_write();
		u_fscr_host.reg_wr(8'h9C, 8'h62, nb);
		chk(nb[7:0], 8'h00);
		chk(status_q, 8'h00);
		u_fscr_host.arm(1'b1);
		chk(status_q, 8'h02);
		u_fscr_host.reg_wr(8'h1C, 8'h62, nb);
		chk(nb[7:0], 8'h04);
		chk(status_q, 8'h1E);
		chk(config_q, 8'h62);
		chk(side(), 8'h15);
	endtask : t_write

	// Lock with protect pin low freezes the registers, origin stays set
	task automatic t_lock();
		u_fscr_host.reg_wr(8'h9C, 8'h6A, nb);
		chk(status_q, 8'h9E);
		chk(config_q, 8'h6A);
		set_wp(1'b0);
		u_fscr_host.reg_wr(8'h00, 8'h00, nb);
		chk(nb[7:0], 8'h00);
		chk(status_q, 8'h9E);
		chk(config_q, 8'h6A);
		set_wp(1'b1);
		u_fscr_host.reg_wr(8'h1C, 8'h4B, nb);
		chk(status_q, 8'h1E);
		chk(config_q, 8'h6B);
		chk(side(), 8'h1D);
	endtask : t_lock

	// Frozen protection bits, status-only write, then disarm refuses writes
	task automatic t_freeze();
		fscr_pkg::fscr_cmd_t c;
		c = '0;
		u_fscr_host.reg_wr(8'h00, 8'hE8, nb);
		chk(status_q, 8'h1E);
		chk(config_q, 8'hE9);
		// Write without a configuration byte leaves configuration alone
		c.reg_write = 1'b1;
		u_fscr_host.pulse(c);
		repeat (5) @(negedge clk);
		chk(config_q, 8'hE9);
		chk(status_q, 8'h1E);
		u_fscr_host.arm(1'b0);
		chk(status_q, 8'h1C);
		u_fscr_host.reg_wr(8'h80, 8'h6B, nb);
		chk(nb[7:0], 8'h00);
		chk(status_q, 8'h1C);
		chk(side(), 8'h0B);
	endtask : t_freeze

	// Engine flags: failures, clear, suspends, busy
	task automatic t_engine();
		eng.prog_fail = 1'b1;
		@(negedge clk);
		eng = '0;
		eng.erase_fail = 1'b1;
		@(negedge clk);
		eng = '0;
		@(negedge clk);
		chk(status_q, 8'h7C);
		eng.clr_err = 1'b1;
		@(negedge clk);
		eng = '0;
		eng.prog_susp = 1'b1;
		eng.erase_susp = 1'b1;
		eng.busy = 1'b1;
		@(negedge clk);
		chk(status_q, 8'h1D);
		chk(suspend_q, 8'h03);
		eng.erase_susp = 1'b0;
		@(negedge clk);
		chk(suspend_q, 8'h01);
		// Armed but busy: array work must wait
		u_fscr_host.arm(1'b1);
		chk(status_q, 8'h1F);
		chk(side(), 8'h0B);
		// Failure and clear together: the failure wins
		eng = '0;
		eng.clr_err = 1'b1;
		eng.prog_fail = 1'b1;
		@(negedge clk);
		eng = '0;
		@(negedge clk);
		chk(status_q, 8'h5E);
		chk(side(), 8'h1B);
	endtask : t_engine

	// Main sequence
	initial begin
		failures = 0;
		n_tests = 0;
		cycles = 0;
		rst_n = 1'b0;
		wp_pin_n = 1'b1;
		eng = '0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_write();
		t_lock();
		t_freeze();
		t_engine();
		report_and_stop();
	end
endmodule : fscr_regs_tb
